// ### hdl/vpp_pkg.sv
// package of constants and types for the voice pcm/i2s audio port
package vpp_pkg;
    // ****************************************
    // clocking
    // ****************************************
    localparam int SYS_HZ = 10_000_000;
    localparam int PCM_BCLK_HZ = 144_000;
    localparam int I2S_BCLK_HZ = 512_000;
    localparam int FRAME_US = 125;
    localparam int FRAME_HZ = 1_000_000 / FRAME_US;
    localparam logic [25:0] DDS_MOD = 26'(SYS_HZ);
    localparam logic [25:0] PCM_DDS_INC = 26'(2 * PCM_BCLK_HZ);
    localparam logic [25:0] I2S_DDS_INC = 26'(2 * I2S_BCLK_HZ);
    localparam logic [6:0] PCM_BITS = 7'(PCM_BCLK_HZ / FRAME_HZ);
    localparam logic [6:0] I2S_BITS = 7'(I2S_BCLK_HZ / FRAME_HZ);
    localparam logic [6:0] PCM_SYNC_LEN = 7'h02;
    localparam logic [6:0] I2S_SYNC_LEN = 7'h01;
    localparam logic [6:0] SAMPLE_BITS = 7'h10;
    localparam logic [6:0] BIT_IDLE = 7'h7f;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_ROUTE = 8'h04;
    localparam logic [7:0] ADDR_GAIN = 8'h08;
    localparam logic [7:0] ADDR_TXDATA = 8'h0c;
    localparam logic [7:0] ADDR_RXDATA = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;
    localparam int CTRL_FMT_BIT = 0;
    localparam int CTRL_ADV_BIT = 1;
    localparam int CTRL_DIG_BIT = 2;
    localparam int ST_HEADSET_BIT = 0;
    localparam int ST_DIGITAL_BIT = 1;
    localparam int ST_RXNEW_BIT = 2;
    localparam int ST_PIN_BIT = 3;
    localparam logic [9:0] ROUTE_RESET = 10'h000;
    localparam logic [2:0] GAIN_RESET = 3'h4;
    localparam logic [2:0] GAIN_MAX_CODE = 3'h6;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ****************************************
    // path selections
    // ****************************************
    localparam logic [1:0] SEL_HANDSET = 2'h0;
    localparam logic [1:0] SEL_HEADSET = 2'h1;
    localparam logic [1:0] SEL_DIGITAL = 2'h2;
    localparam logic [1:0] SEL_NONE = 2'h3;
    localparam int SOUND_TYPES = 4;
    typedef logic [1:0] vpp_sel_t;
    // index 0 speech, 1 keypad tones, 2 rings, 3 alerts
    typedef struct packed {
        vpp_sel_t speech_in;
        vpp_sel_t [SOUND_TYPES-1:0] out_sel;
    } vpp_route_t;
    typedef enum logic [1:0] {
        LNK_IDLE = 2'b01,
        LNK_RUN = 2'b10
    } vpp_link_t;
    typedef struct packed {
        logic clk;
        logic sync;
        logic dout;
        logic dout_oe;
    } vpp_bus_t;
    typedef struct packed {
        vpp_link_t lnk;
        logic [24:0] acc;
        logic [6:0] bit_cnt;
        logic fmt_frm;
        logic [15:0] tx_shift;
        logic [15:0] rx_shift;
        vpp_bus_t bus;
        logic fmt_i2s;
        logic adv;
        logic dig_en;
        vpp_route_t route;
        logic [2:0] gain;
        logic [15:0] tx_data;
        logic [15:0] rx_data;
        logic rx_new;
        logic hs_s1;
        logic hs_s2;
        logic din_s1;
        logic din_s2;
        vpp_route_t route_out;
        logic diff_en;
        logic mono_en;
        logic hs_mic_en;
        logic hd_mic_en;
        logic dig_act;
        logic headset_act;
        logic aw_have;
        logic [7:0] aw_addr;
        logic w_have;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } vpp_state_t;
endpackage

// ### hdl/vpp_voice_port.sv
// voice pcm/i2s serial audio port with audio path selection and axi4-lite registers
`timescale 1ns/100ps
`default_nettype none
module vpp_voice_port
    import vpp_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    output logic voice_bit_clk_o,
    output logic voice_frame_sync_o,
    output logic voice_data_out_o,
    output logic voice_data_out_oe_o,
    input wire logic voice_data_in_i,
    input wire logic headset_select_n_i,
    output logic diff_speaker_en_o,
    output logic mono_speaker_en_o,
    output logic [2:0] mono_speaker_gain_o,
    output logic handset_mic_en_o,
    output logic headset_mic_en_o,
    output logic digital_path_en_o,
    output vpp_route_t sound_route_o
);
    // ****************************************
    // state
    // ****************************************
    vpp_state_t st;
    vpp_state_t next_st;
    logic [31:0] wmask;
    logic [31:0] wval;
    logic [25:0] sum;
    logic [6:0] last_bit;
    logic [6:0] sync_len;
    logic [6:0] win_end;
    logic [6:0] nb;
    logic [25:0] inc;
    logic headset;
    logic dig_any;

    localparam vpp_state_t ST_RESET = '{
        lnk: LNK_IDLE,
        acc: 25'h0000000,
        bit_cnt: BIT_IDLE,
        fmt_frm: 1'b0,
        tx_shift: 16'h0000,
        rx_shift: 16'h0000,
        bus: '{clk: 1'b0, sync: 1'b0, dout: 1'b0, dout_oe: 1'b0},
        fmt_i2s: 1'b0,
        adv: 1'b0,
        dig_en: 1'b0,
        route: ROUTE_RESET,
        gain: GAIN_RESET,
        tx_data: 16'h0000,
        rx_data: 16'h0000,
        rx_new: 1'b0,
        hs_s1: 1'b1,
        hs_s2: 1'b1,
        din_s1: 1'b0,
        din_s2: 1'b0,
        route_out: ROUTE_RESET,
        diff_en: 1'b1,
        mono_en: 1'b0,
        hs_mic_en: 1'b1,
        hd_mic_en: 1'b0,
        dig_act: 1'b0,
        headset_act: 1'b0,
        aw_have: 1'b0,
        aw_addr: 8'h00,
        w_have: 1'b0,
        wdata: 32'h00000000,
        wstrb: 4'h0,
        awready: 1'b0,
        wready: 1'b0,
        bvalid: 1'b0,
        bresp: RESP_OKAY,
        arready: 1'b0,
        rvalid: 1'b0,
        rdata: 32'h00000000,
        rresp: RESP_OKAY
    };

    // ****************************************
    // register read view
    // ****************************************
    function automatic logic [31:0] reg_view(input vpp_state_t s, input logic [7:0] addr);
        logic [31:0] v;
        v = 32'h00000000;
        case (addr)
            ADDR_CTRL: begin
                v[CTRL_FMT_BIT] = s.fmt_i2s;
                v[CTRL_ADV_BIT] = s.adv;
                v[CTRL_DIG_BIT] = s.dig_en;
            end
            ADDR_ROUTE: v[9:0] = s.route;
            ADDR_GAIN: v[2:0] = s.gain;
            ADDR_TXDATA: v[15:0] = s.tx_data;
            ADDR_RXDATA: v[15:0] = s.rx_data;
            ADDR_STATUS: begin
                v[ST_HEADSET_BIT] = s.headset_act;
                v[ST_DIGITAL_BIT] = s.dig_act;
                v[ST_RXNEW_BIT] = s.rx_new;
                v[ST_PIN_BIT] = s.hs_s2;
            end
            default: v = 32'h00000000;
        endcase
        return v;
    endfunction

    function automatic logic addr_hit(input logic [7:0] addr);
        return (addr == ADDR_CTRL) || (addr == ADDR_ROUTE) || (addr == ADDR_GAIN) ||
            (addr == ADDR_TXDATA) || (addr == ADDR_RXDATA) || (addr == ADDR_STATUS);
    endfunction

    always_comb begin
        next_st = st;
        wmask = {{8{st.wstrb[3]}}, {8{st.wstrb[2]}}, {8{st.wstrb[1]}}, {8{st.wstrb[0]}}};
        wval = (reg_view(st, st.aw_addr) & ~wmask) | (st.wdata & wmask);
        sum = 26'h0000000;
        nb = 7'h00;
        headset = 1'b0;
        dig_any = 1'b0;
        // pins from outside pass two flops before use
        next_st.hs_s1 = headset_select_n_i;
        next_st.hs_s2 = st.hs_s1;
        next_st.din_s1 = voice_data_in_i;
        next_st.din_s2 = st.din_s1;

        // ****************************************
        // axi4-lite write
        // ****************************************
        if (st.awready && s_axi_awvalid_i) begin
            next_st.aw_have = 1'b1;
            next_st.aw_addr = s_axi_awaddr_i;
        end
        if (st.wready && s_axi_wvalid_i) begin
            next_st.w_have = 1'b1;
            next_st.wdata = s_axi_wdata_i;
            next_st.wstrb = s_axi_wstrb_i;
        end
        if (st.bvalid && s_axi_bready_i) begin
            next_st.bvalid = 1'b0;
        end
        if (st.aw_have && st.w_have && !st.bvalid) begin
            next_st.aw_have = 1'b0;
            next_st.w_have = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = addr_hit(st.aw_addr) ? RESP_OKAY : RESP_SLVERR;
            case (st.aw_addr)
                ADDR_CTRL: begin
                    next_st.fmt_i2s = wval[CTRL_FMT_BIT];
                    next_st.adv = wval[CTRL_ADV_BIT];
                    next_st.dig_en = wval[CTRL_DIG_BIT];
                end
                ADDR_ROUTE: next_st.route = wval[9:0];
                ADDR_GAIN: begin
                    // codes above the 0 db step clamp rather than wrap
                    next_st.gain = (wval[2:0] > GAIN_MAX_CODE) ? GAIN_MAX_CODE : wval[2:0];
                end
                ADDR_TXDATA: next_st.tx_data = wval[15:0];
                ADDR_STATUS: begin
                    if (st.wdata[ST_RXNEW_BIT] && wmask[ST_RXNEW_BIT]) begin
                        next_st.rx_new = 1'b0;
                    end
                end
                default: next_st.bresp = RESP_SLVERR;
            endcase
        end

        // ****************************************
        // axi4-lite read
        // ****************************************
        if (st.rvalid && s_axi_rready_i) begin
            next_st.rvalid = 1'b0;
        end
        if (st.arready && s_axi_arvalid_i) begin
            next_st.rvalid = 1'b1;
            next_st.rdata = reg_view(st, s_axi_araddr_i);
            next_st.rresp = addr_hit(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
        end
        next_st.awready = !next_st.aw_have && !next_st.bvalid;
        next_st.wready = !next_st.w_have && !next_st.bvalid;
        next_st.arready = !next_st.rvalid;

        // ****************************************
        // audio path selection
        // ****************************************
        if (st.adv) begin
            next_st.route_out = st.route;
        end else begin
            headset = !st.hs_s2;
            for (int i = 0; i < SOUND_TYPES; i++) begin
                next_st.route_out.out_sel[i] = headset ? SEL_HEADSET : SEL_HANDSET;
            end
            next_st.route_out.speech_in = headset ? SEL_HEADSET : SEL_HANDSET;
        end
        next_st.diff_en = 1'b0;
        next_st.mono_en = 1'b0;
        for (int i = 0; i < SOUND_TYPES; i++) begin
            if (next_st.route_out.out_sel[i] == SEL_HANDSET) begin
                next_st.diff_en = 1'b1;
            end
            if (next_st.route_out.out_sel[i] == SEL_HEADSET) begin
                next_st.mono_en = 1'b1;
            end
            if (next_st.route_out.out_sel[i] == SEL_DIGITAL) begin
                dig_any = 1'b1;
            end
        end
        next_st.hs_mic_en = (next_st.route_out.speech_in == SEL_HANDSET);
        next_st.hd_mic_en = (next_st.route_out.speech_in == SEL_HEADSET);
        next_st.headset_act = next_st.mono_en;
        dig_any = dig_any || (next_st.route_out.speech_in == SEL_DIGITAL);
        next_st.dig_act = st.adv ? dig_any : st.dig_en;

        // ****************************************
        // serial bus master
        // ****************************************
        inc = st.fmt_frm ? I2S_DDS_INC : PCM_DDS_INC;
        last_bit = st.fmt_frm ? (I2S_BITS - 7'h01) : (PCM_BITS - 7'h01);
        sync_len = st.fmt_frm ? I2S_SYNC_LEN : PCM_SYNC_LEN;
        win_end = sync_len + SAMPLE_BITS;
        case (st.lnk)
            LNK_IDLE: begin
                // bus lines held quiet so an analog-path user sees no activity
                next_st.bus = '{clk: 1'b0, sync: 1'b0, dout: 1'b0, dout_oe: 1'b0};
                next_st.acc = 25'h0000000;
                next_st.bit_cnt = BIT_IDLE;
                next_st.fmt_frm = st.fmt_i2s;
                if (st.dig_act) begin
                    next_st.lnk = LNK_RUN;
                end
            end
            LNK_RUN: begin
                sum = {1'b0, st.acc} + inc;
                if (!st.dig_act) begin
                    // stops at once; a frame in flight is cut short
                    next_st.lnk = LNK_IDLE;
                    next_st.bus = '{clk: 1'b0, sync: 1'b0, dout: 1'b0, dout_oe: 1'b0};
                end else if (sum >= DDS_MOD) begin
                    // fractional divider: edges jitter by one sys clock, average rate exact
                    next_st.acc = 25'(sum - DDS_MOD);
                    next_st.bus.clk = !st.bus.clk;
                    if (!st.bus.clk) begin
                        nb = (st.bit_cnt >= last_bit) ? 7'h00 : (st.bit_cnt + 7'h01);
                        next_st.bit_cnt = nb;
                        if (nb == 7'h00) begin
                            next_st.fmt_frm = st.fmt_i2s;
                            next_st.tx_shift = st.tx_data;
                        end
                        next_st.bus.sync = (nb < sync_len);
                        if ((nb >= sync_len) && (nb < win_end)) begin
                            next_st.bus.dout = st.tx_shift[15];
                            next_st.bus.dout_oe = 1'b1;
                            next_st.tx_shift = {st.tx_shift[14:0], 1'b0};
                        end else begin
                            next_st.bus.dout = 1'b0;
                            next_st.bus.dout_oe = 1'b0;
                        end
                    end else if ((st.bit_cnt >= sync_len) && (st.bit_cnt < win_end)) begin
                        next_st.rx_shift = {st.rx_shift[14:0], st.din_s2};
                        if (st.bit_cnt == (win_end - 7'h01)) begin
                            next_st.rx_data = {st.rx_shift[14:0], st.din_s2};
                            next_st.rx_new = 1'b1;
                        end
                    end
                end else begin
                    next_st.acc = sum[24:0];
                end
            end
            default: next_st.lnk = LNK_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            st <= ST_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign s_axi_awready_o = st.awready;
    assign s_axi_wready_o = st.wready;
    assign s_axi_bresp_o = st.bresp;
    assign s_axi_bvalid_o = st.bvalid;
    assign s_axi_arready_o = st.arready;
    assign s_axi_rdata_o = st.rdata;
    assign s_axi_rresp_o = st.rresp;
    assign s_axi_rvalid_o = st.rvalid;
    assign voice_bit_clk_o = st.bus.clk;
    assign voice_frame_sync_o = st.bus.sync;
    assign voice_data_out_o = st.bus.dout;
    assign voice_data_out_oe_o = st.bus.dout_oe;
    assign diff_speaker_en_o = st.diff_en;
    assign mono_speaker_en_o = st.mono_en;
    assign mono_speaker_gain_o = st.gain;
    assign handset_mic_en_o = st.hs_mic_en;
    assign headset_mic_en_o = st.hd_mic_en;
    assign digital_path_en_o = st.dig_act;
    assign sound_route_o = st.route_out;
endmodule
`default_nettype wire

// ### verification/vpp_voice_port_sva.sv
// concurrent checks on the voice port pins
`timescale 1ns/100ps
`default_nettype none
module vpp_voice_port_chk
    import vpp_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic s_axi_awvalid_i,
    input wire logic s_axi_awready_o,
    input wire logic s_axi_wvalid_i,
    input wire logic s_axi_wready_o,
    input wire logic s_axi_bvalid_o,
    input wire logic [1:0] s_axi_bresp_o,
    input wire logic voice_bit_clk_o,
    input wire logic voice_frame_sync_o,
    input wire logic voice_data_out_o,
    input wire logic voice_data_out_oe_o,
    input wire logic digital_path_en_o,
    input wire logic diff_speaker_en_o,
    input wire logic mono_speaker_en_o,
    input wire logic [2:0] mono_speaker_gain_o,
    input wire logic handset_mic_en_o,
    input wire vpp_route_t sound_route_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    // ****************************************
    // frame length helper
    // ****************************************
    // first frame after enable is not timed: no earlier sync to count from
    logic [10:0] frm_cnt;
    logic armed;
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i || !digital_path_en_o) begin
            frm_cnt <= 11'h000;
            armed <= 1'b0;
        end else if ($rose(voice_frame_sync_o)) begin
            frm_cnt <= 11'h000;
            armed <= 1'b1;
        end else begin
            frm_cnt <= frm_cnt + 11'h001;
        end
    end
    // ****************************************
    // properties
    // ****************************************
    chk_frame_period: assert property ($rose(voice_frame_sync_o) && armed |-> frm_cnt == 11'h4e1)
        else $error("frame period is not 125 us");
    chk_oe_in_sync: assert property (voice_data_out_oe_o |-> !voice_frame_sync_o)
        else $error("data driven during sync");
    chk_bus_idle: assert property (!digital_path_en_o && !$past(digital_path_en_o) && !$past(digital_path_en_o, 2)
        |-> !voice_bit_clk_o && !voice_frame_sync_o && !voice_data_out_oe_o)
        else $error("bus active while digital path off");
    chk_launch_edge: assert property (digital_path_en_o && $past(digital_path_en_o)
        && $changed({voice_data_out_o, voice_data_out_oe_o, voice_frame_sync_o}) |-> $rose(voice_bit_clk_o))
        else $error("data or sync changed off the rising bit edge");
    chk_sync_shape: assert property ($rose(voice_frame_sync_o) |-> $rose(voice_bit_clk_o) ##1 voice_frame_sync_o[*8])
        else $error("sync pulse badly formed");
    chk_bclk_min: assert property (digital_path_en_o && $past(digital_path_en_o) && $changed(voice_bit_clk_o)
        |=> ($stable(voice_bit_clk_o) || !digital_path_en_o)[*8])
        else $error("bit clock half period too short");
    chk_bclk_max: assert property (digital_path_en_o && $past(digital_path_en_o) && $changed(voice_bit_clk_o)
        |-> ##[1:35] ($changed(voice_bit_clk_o) || !digital_path_en_o))
        else $error("bit clock half period too long");
    chk_gain_limit: assert property (mono_speaker_gain_o <= GAIN_MAX_CODE)
        else $error("gain code above 0 dB");
    chk_reset_paths: assert property ($rose(rst_n_i) |-> diff_speaker_en_o && handset_mic_en_o
        && !mono_speaker_en_o && !digital_path_en_o && mono_speaker_gain_o == GAIN_RESET && sound_route_o == ROUTE_RESET)
        else $error("wrong path state after reset");
    chk_write_answer: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
        |-> ##2 s_axi_bvalid_o)
        else $error("write response missing");
    cover property ($rose(voice_frame_sync_o) && armed);
    cover property ($rose(voice_data_out_oe_o));
    cover property (s_axi_bvalid_o && s_axi_bresp_o == RESP_SLVERR);
endmodule
bind vpp_voice_port vpp_voice_port_chk i_chk (.sys_clk_i, .rst_n_i, .s_axi_awvalid_i, .s_axi_awready_o,
    .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bvalid_o, .s_axi_bresp_o, .voice_bit_clk_o, .voice_frame_sync_o,
    .voice_data_out_o, .voice_data_out_oe_o, .digital_path_en_o, .diff_speaker_en_o, .mono_speaker_en_o,
    .mono_speaker_gain_o, .handset_mic_en_o, .sound_route_o);
`default_nettype wire

// ### verification/vpp_codec_model.sv
// behavioural application codec on the serial audio bus
`timescale 1ns/100ps
`default_nettype none
module vpp_codec_model (
    input wire logic bclk_i,
    input wire logic sync_i,
    input wire logic dout_i,
    input wire logic [15:0] tx_word_i,
    input wire logic oe_i,
    output logic din_o,
    output logic [15:0] rx_word_o,
    output logic [6:0] rises_o,
    output logic [6:0] sync_rises_o,
    output logic [6:0] oe_rises_o,
    output int frames_o
);
    logic [6:0] cnt;
    logic [6:0] nr;
    logic [6:0] ns;
    logic [6:0] no;
    logic [15:0] sh;
    logic ps;
    initial begin
        {din_o, rx_word_o, rises_o, sync_rises_o, oe_rises_o, cnt, nr, ns, no, sh, ps} = '0;
        frames_o = 0;
    end
    // ****************************************
    // launch on rising bit edge
    // ****************************************
    always @(posedge bclk_i) begin
        #1;
        if (sync_i && !ps) begin
            rises_o = nr;
            sync_rises_o = ns;
            oe_rises_o = no;
            {nr, ns, no} = '0;
            frames_o++;
        end
        ps = sync_i;
        nr++;
        ns += 7'(sync_i);
        no += 7'(oe_i);
        cnt = sync_i ? 7'h00 : cnt + 7'h01;
        if (cnt >= 7'h01 && cnt <= 7'h10) begin
            din_o = tx_word_i[16 - cnt];
        end else begin
            din_o = ~din_o; // toggled outside the word, no stale level
        end
    end
    // ****************************************
    // sample on falling bit edge
    // ****************************************
    always @(negedge bclk_i) begin
        if (cnt >= 7'h01 && cnt <= 7'h10) begin
            sh = {sh[14:0], dout_i};
            if (cnt == 7'h10) begin
                rx_word_o = sh;
            end
        end
    end
endmodule
`default_nettype wire

// ### verification/testbench.sv
// register and serial link tests of the voice port
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; $display("Error %0t got %h exp %h", $time, g, e); end end
module testbench;
    import vpp_pkg::*;
    logic sys_clk_i, rst_n_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i;
    logic [7:0] s_axi_awaddr_i, s_axi_araddr_i;
    logic [31:0] s_axi_wdata_i, s_axi_rdata_o;
    logic [3:0] s_axi_wstrb_i;
    logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
    logic voice_bit_clk_o, voice_frame_sync_o, voice_data_out_o, voice_data_out_oe_o, voice_data_in_i;
    logic headset_select_n_i, diff_speaker_en_o, mono_speaker_en_o, handset_mic_en_o, headset_mic_en_o;
    logic digital_path_en_o;
    logic [2:0] mono_speaker_gain_o;
    vpp_route_t sound_route_o;
    logic [15:0] tx_word, rx_word;
    logic [6:0] rises, sync_rises, oe_rises;
    int frames, n_mismatch, num_checks, cyc;
    vpp_voice_port i_dut (.sys_clk_i, .rst_n_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
        .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o,
        .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o,
        .s_axi_rvalid_o, .s_axi_rready_i, .voice_bit_clk_o, .voice_frame_sync_o, .voice_data_out_o,
        .voice_data_out_oe_o, .voice_data_in_i, .headset_select_n_i, .diff_speaker_en_o, .mono_speaker_en_o,
        .mono_speaker_gain_o, .handset_mic_en_o, .headset_mic_en_o, .digital_path_en_o, .sound_route_o);
    vpp_codec_model i_codec (.bclk_i(voice_bit_clk_o), .sync_i(voice_frame_sync_o), .dout_i(voice_data_out_o),
        .tx_word_i(tx_word), .oe_i(voice_data_out_oe_o), .din_o(voice_data_in_i), .rx_word_o(rx_word),
        .rises_o(rises), .sync_rises_o(sync_rises), .oe_rises_o(oe_rises), .frames_o(frames));
    // ****************************************
    // axi4-lite master tasks
    // ****************************************
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= d;
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge sys_clk_i);
            if (s_axi_awvalid_i && s_axi_awready_o === 1'b1) begin
                aw_done = 1'b1;
                s_axi_awvalid_i <= 1'b0;
            end
            if (s_axi_wvalid_i && s_axi_wready_o === 1'b1) begin
                w_done = 1'b1;
                s_axi_wvalid_i <= 1'b0;
            end
        end
        do @(posedge sys_clk_i); while (s_axi_bvalid_o !== 1'b1);
        `CHK(s_axi_bresp_o, er)
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1'b1;
        do @(posedge sys_clk_i); while (s_axi_arready_o !== 1'b1);
        s_axi_arvalid_i <= 1'b0;
        do @(posedge sys_clk_i); while (s_axi_rvalid_o !== 1'b1);
        `CHK(s_axi_rdata_o, e)
        `CHK(s_axi_rresp_o, er)
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask
    task automatic wait_frames(input int n);
        int f0;
        f0 = frames;
        while (frames - f0 < n) @(posedge sys_clk_i);
    endtask
    task automatic final_report();
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // ****************************************
    // clock and watchdog
    // ****************************************
    initial begin
        sys_clk_i = 1'b0;
        forever #50 sys_clk_i = ~sys_clk_i;
    end
    // ceiling well above the six frames and register traffic of the run
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 40000) begin
            n_mismatch++;
            final_report();
        end
    end
    // ****************************************
    // tests
    // ****************************************
    initial begin
        {rst_n_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_arvalid_i, s_axi_awaddr_i, s_axi_araddr_i} = '0;
        s_axi_wdata_i = 32'h0;
        s_axi_wstrb_i = 4'hf;
        s_axi_bready_i = 1'b1;
        s_axi_rready_i = 1'b1;
        headset_select_n_i = 1'b1;
        tx_word = 16'h9c1e;
        repeat (5) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        tick(3);
        `CHK({diff_speaker_en_o, handset_mic_en_o, mono_speaker_en_o, headset_mic_en_o}, 4'hc)
        `CHK({digital_path_en_o, sound_route_o, mono_speaker_gain_o}, 14'h0004)
        rd(ADDR_CTRL, 32'h0, RESP_OKAY);
        rd(ADDR_STATUS, 32'h8, RESP_OKAY);
        headset_select_n_i <= 1'b0;
        tick(5);
        `CHK({diff_speaker_en_o, handset_mic_en_o, mono_speaker_en_o, headset_mic_en_o}, 4'h3)
        `CHK(sound_route_o, 10'h155)
        rd(ADDR_STATUS, 32'h1, RESP_OKAY);
        headset_select_n_i <= 1'b1;
        tick(5);
        `CHK({diff_speaker_en_o, mono_speaker_en_o, sound_route_o}, 12'h800)
        for (int i = 0; i < 8; i++) begin
            wr(ADDR_GAIN, 32'(i), RESP_OKAY);
            rd(ADDR_GAIN, (i > 6) ? 32'h6 : 32'(i), RESP_OKAY);
            `CHK(mono_speaker_gain_o, (i > 6) ? 3'h6 : 3'(i))
        end
        wr(8'h18, 32'h1, RESP_SLVERR);
        rd(8'h18, 32'h0, RESP_SLVERR);
        // advanced mode: pin low must not move routing
        wr(ADDR_CTRL, 32'h2, RESP_OKAY);
        wr(ADDR_ROUTE, 32'h1c8, RESP_OKAY);
        rd(ADDR_ROUTE, 32'h1c8, RESP_OKAY);
        headset_select_n_i <= 1'b0;
        tick(5);
        `CHK(sound_route_o, 10'h1c8)
        `CHK(digital_path_en_o, 1'b1)
        headset_select_n_i <= 1'b1;
        wr(ADDR_CTRL, 32'h0, RESP_OKAY);
        // pcm link, negative sample inbound
        wr(ADDR_TXDATA, 32'ha5c3, RESP_OKAY);
        wr(ADDR_CTRL, 32'h4, RESP_OKAY);
        tick(2);
        `CHK(digital_path_en_o, 1'b1)
        wait_frames(3);
        `CHK(rx_word, 16'ha5c3)
        `CHK({rises, sync_rises, oe_rises}, {7'h12, 7'h02, 7'h10})
        rd(ADDR_RXDATA, 32'h9c1e, RESP_OKAY);
        rd(ADDR_STATUS, 32'he, RESP_OKAY);
        wr(ADDR_STATUS, 32'h4, RESP_OKAY);
        rd(ADDR_STATUS, 32'ha, RESP_OKAY);
        // i2s link
        tx_word = 16'h0180;
        wr(ADDR_TXDATA, 32'h7f01, RESP_OKAY);
        wr(ADDR_CTRL, 32'h0, RESP_OKAY);
        wr(ADDR_CTRL, 32'h5, RESP_OKAY);
        wait_frames(3);
        `CHK(rx_word, 16'h7f01)
        `CHK({rises, sync_rises, oe_rises}, {7'h40, 7'h01, 7'h10})
        rd(ADDR_RXDATA, 32'h0180, RESP_OKAY);
        wr(ADDR_CTRL, 32'h0, RESP_OKAY);
        tick(3);
        `CHK({digital_path_en_o, voice_bit_clk_o, voice_data_out_oe_o}, 3'h0)
        final_report();
    end
endmodule
`default_nettype wire
